// file: pbwc_top.sv
/*
  pbwc_top: power state sequencer driven by the front-panel switch, wake
  sources and operating-system requests.
  assumes: all inputs are asynchronous pins and are synchronised here;
  last_on_state comes from battery-backed storage and is valid at reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pbwc_top #(
  parameter int unsigned DEBOUNCE_CYCLES = pbwc_pkg::DEBOUNCE_CYC,
  parameter longint unsigned LONG_CYCLES = pbwc_pkg::LONG_PRESS_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // front panel switch, active low pin
  input  wire logic                  pwr_switch_n,
  // wake sources
  input  wire pbwc_pkg::pbwc_wake_t  wake_in,
  // operating system requests
  input  wire pbwc_pkg::pbwc_os_req_t os_req,
  // mains restore policy
  input  wire logic                  soft_off_en,
  input  wire logic                  last_on_state,
  // power outputs
  output var  pbwc_pkg::pbwc_power_t power_out,
  output var  pbwc_pkg::pbwc_state_t sys_state,
  output var  logic                  state_saved_on
);

  // ==========================================================
  // parameter checks
  // refused at elaboration: counters are 32 bits, long must outlast debounce
  if (DEBOUNCE_CYCLES < 1 || LONG_CYCLES <= DEBOUNCE_CYCLES ||
      LONG_CYCLES >= 64'h0000_0000_ffff_ffff) begin : g_bad_timing
    $error("pbwc_top: bad timing parameters");
  end

  localparam logic [31:0] DEB_LIM  = 32'(DEBOUNCE_CYCLES);
  localparam logic [31:0] LONG_LIM = 32'(LONG_CYCLES);

  // ==========================================================
  // reset release and input synchronisers
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // pins: switch, four wakes, three requests, two policy bits
  localparam int unsigned IN_W = 10;
  logic [IN_W-1:0] in_raw, meta_r, sync_r;
  assign in_raw = {~pwr_switch_n, wake_in, os_req, soft_off_en, last_on_state};
  // no reset on the synchronisers: the policy pins held during reset must
  // already be settled at the first edge after release, or the mains-restore
  // decision would always see zeros and fall back to off
  always_ff @(posedge ref_clk) begin
    meta_r <= in_raw;
    sync_r <= meta_r;
  end

  logic                  sw_raw;
  pbwc_pkg::pbwc_wake_t  wk;
  pbwc_pkg::pbwc_os_req_t rq;
  logic                  soe_s, last_on_s;
  assign {sw_raw, wk, rq, soe_s, last_on_s} = sync_r;

  // ==========================================================
  // state record
  typedef struct packed {
    logic                  started;   // mains-restore decision taken
    logic                  sw_deb;    // debounced switch level
    logic [31:0]           deb_cnt;
    logic [31:0]           hold_cnt;
    logic                  long_done; // long action already taken
    pbwc_pkg::pbwc_state_t st;
    logic                  was_on;
  } pbwc_regs_t;

  pbwc_regs_t s_r, s_nxt;
  logic short_press, long_press, any_wake, full_wake;

  always_comb begin
    s_nxt       = s_r;
    short_press = 1'b0;
    long_press  = 1'b0;
    // debounce: level must hold steady for the debounce window
    if (sw_raw == s_r.sw_deb) begin
      s_nxt.deb_cnt = '0;
    end else if (s_r.deb_cnt >= DEB_LIM - 32'h1) begin
      s_nxt.sw_deb  = sw_raw;
      s_nxt.deb_cnt = '0;
    end else begin
      s_nxt.deb_cnt = s_r.deb_cnt + 32'h1;
    end
    // hold timing; long fires once the threshold is crossed
    if (s_r.sw_deb) begin
      if (s_r.hold_cnt < LONG_LIM) begin
        s_nxt.hold_cnt = s_r.hold_cnt + 32'h1;
      end else if (!s_r.long_done) begin
        long_press      = 1'b1;
        s_nxt.long_done = 1'b1;
      end
    end else begin
      // release below threshold counts as a short press
      short_press     = s_r.sw_deb == 1'b0 && s_r.hold_cnt != '0 && !s_r.long_done;
      s_nxt.hold_cnt  = '0;
      s_nxt.long_done = 1'b0;
    end
    // wake qualification by source and state
    any_wake  = short_press | wk.rtc_alarm;
    full_wake = any_wake | wk.lan | wk.pme | wk.usb;

    case (s_r.st)
      pbwc_pkg::PBWC_G3: begin
        // first cycle after standby power: restore prior state
        if (!s_r.started) begin
          s_nxt.started = 1'b1;
          s_nxt.st = (soe_s && last_on_s) ? pbwc_pkg::PBWC_S0 : pbwc_pkg::PBWC_S5;
        end
      end
      pbwc_pkg::PBWC_S0: begin
        if (long_press) begin
          s_nxt.st = pbwc_pkg::PBWC_S5;
        end else if (short_press) begin
          s_nxt.st = pbwc_pkg::PBWC_S3;
        end else if (rq.soft_off) begin
          s_nxt.st = pbwc_pkg::PBWC_S5;
        end else if (rq.sleep_s3) begin
          s_nxt.st = pbwc_pkg::PBWC_S3;
        end else if (rq.sleep_s1) begin
          s_nxt.st = pbwc_pkg::PBWC_S1;
        end
      end
      pbwc_pkg::PBWC_S1, pbwc_pkg::PBWC_S3: begin
        if (long_press) begin
          s_nxt.st = pbwc_pkg::PBWC_S5;
        end else if (full_wake) begin
          s_nxt.st = pbwc_pkg::PBWC_S0;
        end
      end
      pbwc_pkg::PBWC_S5: begin
        // lan, pme and usb ignored here
        if (any_wake) begin
          s_nxt.st = pbwc_pkg::PBWC_S0;
        end
      end
      default: s_nxt.st = pbwc_pkg::PBWC_S5;
    endcase
    // remembered on/off level for the next mains loss
    if (s_nxt.st == pbwc_pkg::PBWC_S0) begin
      s_nxt.was_on = 1'b1;
    end else if (s_nxt.st == pbwc_pkg::PBWC_S5) begin
      s_nxt.was_on = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{started: 1'b0, sw_deb: 1'b0, deb_cnt: '0, hold_cnt: '0,
               long_done: 1'b0, st: pbwc_pkg::PBWC_G3, was_on: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // power outputs, registered from state; resume only out of sleep
  pbwc_pkg::pbwc_power_t pw_r, pw_nxt;
  always_comb begin
    pw_nxt              = '0;
    pw_nxt.dev_state    = pbwc_pkg::DSTATE_D3;
    pw_nxt.resume       = 1'b0;
    pw_nxt.cold_boot    = 1'b0;
    case (s_nxt.st)
      pbwc_pkg::PBWC_S0: begin
        pw_nxt.supply_on = 1'b1;
        pw_nxt.cpu_power = 1'b1;
        pw_nxt.mem_power = 1'b1;
        pw_nxt.dev_state = pbwc_pkg::DSTATE_D0;
        // entry from S1 or S3 resumes, entry from S5 or mains cold boots
        pw_nxt.resume    = s_r.st == pbwc_pkg::PBWC_S3 || s_r.st == pbwc_pkg::PBWC_S1;
        pw_nxt.cold_boot = s_r.st == pbwc_pkg::PBWC_S5 || s_r.st == pbwc_pkg::PBWC_G3;
      end
      pbwc_pkg::PBWC_S1: begin
        pw_nxt.supply_on = 1'b1;
        pw_nxt.cpu_power = 1'b1;
        pw_nxt.mem_power = 1'b1;
      end
      // cpu off, memory kept for context
      pbwc_pkg::PBWC_S3: pw_nxt.mem_power = 1'b1;
      // nothing kept but wake logic
      pbwc_pkg::PBWC_S5: pw_nxt.mem_power = 1'b0;
      default:           pw_nxt.mem_power = 1'b0;
    endcase
    // short press in S0 is reported to the os as a sleep event; a one-cycle
    // pulse that rides with the entry into S3, so the os knows the user
    // asked for the suspend rather than software
    pw_nxt.sleep_button = short_press && s_r.st == pbwc_pkg::PBWC_S0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pw_r <= '{supply_on: 1'b0, cpu_power: 1'b0, mem_power: 1'b0, cold_boot: 1'b0,
                resume: 1'b0, dev_state: pbwc_pkg::DSTATE_D3, sleep_button: 1'b0};
    end else begin
      pw_r <= pw_nxt;
    end
  end

  assign power_out      = pw_r;
  assign sys_state      = s_r.st;
  assign state_saved_on = s_r.was_on;

endmodule
`default_nettype wire

// file: pbwc_pkg.sv
/*
  pbwc_pkg: constants, state encodings and carrier structs for the power
  button and wake controller.
  assumes: a single 250 MHz standby clock; no software-visible registers.
*/
// Overview of operation
// - soft-off, short press powers the system on
// - working: short press sleeps, long forces off
// - sleeping: short press wakes, long powers off
// - switch and alarm wake from S1, S3, S5
// - lan, pme, usb wake only from S1, S3
// - S3 cuts processor power, keeps memory context
// - S5 keeps no context, leaving needs cold boot
// - S3/S5 hold devices in D3, wake logic powered
// - software soft-off path removes system power
// - after mains loss, restore prior on/off state
package pbwc_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned DEBOUNCE_US  = 10;
  localparam int unsigned LONG_PRESS_S = 4;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam longint unsigned LONG_PRESS_CYC = 64'(LONG_PRESS_S) * 64'(CLK_MHZ) * 64'd1000000;
  localparam int unsigned CNT_W        = 32;

  // ==========================================================
  // system sleeping states, one-hot
  typedef enum logic [4:0] {
    PBWC_S0   = 5'h01,
    PBWC_S1   = 5'h02,
    PBWC_S3   = 5'h04,
    PBWC_S5   = 5'h08,
    PBWC_G3   = 5'h10
  } pbwc_state_t;

  // device power state codes
  localparam logic [1:0] DSTATE_D0 = 2'h0;
  localparam logic [1:0] DSTATE_D3 = 2'h3;

  // ==========================================================
  // operating system requests and wake sources
  typedef struct packed {
    logic sleep_s1;
    logic sleep_s3;
    logic soft_off;
  } pbwc_os_req_t;

  typedef struct packed {
    logic rtc_alarm;
    logic lan;
    logic pme;
    logic usb;
  } pbwc_wake_t;

  typedef struct packed {
    logic       supply_on;
    logic       cpu_power;
    logic       mem_power;
    logic       cold_boot;
    logic       resume;
    logic [1:0] dev_state;
    logic       sleep_button;
  } pbwc_power_t;

endpackage

// file: pbwc_asserts.sv
/* pbwc_asserts: port timing checks for pbwc_top.
   assumes: bound into pbwc_top; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module pbwc_asserts (
  // clock, reset, far side
  input wire logic                   ref_clk,
  input wire logic                   reset_n,
  input wire logic                   pwr_switch_n,
  input wire pbwc_pkg::pbwc_wake_t   wake_in,
  input wire pbwc_pkg::pbwc_os_req_t os_req,
  // outputs
  input wire pbwc_pkg::pbwc_power_t  power_out,
  input wire pbwc_pkg::pbwc_state_t  sys_state,
  input wire logic                   state_saved_on
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ====================
  // state decode; pw packs supply, cpu, mem, device state
  wire       s0 = sys_state == pbwc_pkg::PBWC_S0;
  wire       s1 = sys_state == pbwc_pkg::PBWC_S1;
  wire       s3 = sys_state == pbwc_pkg::PBWC_S3;
  wire       s5 = sys_state == pbwc_pkg::PBWC_S5;
  wire [4:0] pw = {power_out.supply_on, power_out.cpu_power, power_out.mem_power, power_out.dev_state};
  // rails follow the state in the same cycle
  property p_s0_pw; s0 |-> pw == 5'h1c; endproperty
  a_s0_pw: assert property (p_s0_pw) else $error("S0 power");
  property p_s3_pw; s3 |-> pw == 5'h07; endproperty
  a_s3_pw: assert property (p_s3_pw) else $error("S3 power");
  property p_s5_pw; s5 |-> pw == 5'h03 && !power_out.resume; endproperty
  a_s5_pw: assert property (p_s5_pw) else $error("S5 power");
  // entry pulses tell a cold boot from a resume
  property p_cold; s0 && $past(s5) |-> power_out.cold_boot && !power_out.resume; endproperty
  a_cold: assert property (p_cold) else $error("no cold boot");
  property p_resume; s0 && ($past(s1) || $past(s3)) |-> power_out.resume && !power_out.cold_boot; endproperty
  a_resume: assert property (p_resume) else $error("no resume");
  // quiet switch and alarm keep S5; lan, pme, usb do not count
  property p_s5_hold; (s5 && pwr_switch_n && !wake_in.rtc_alarm) [*8] |=> s5; endproperty
  a_s5_hold: assert property (p_s5_hold) else $error("S5 left");
  // os requests land within the synchroniser delay
  property p_os_s3; s0 && pwr_switch_n && $rose(os_req.sleep_s3) && !os_req.soft_off |-> ##[1:4] s3; endproperty
  a_os_s3: assert property (p_os_s3) else $error("no suspend");
  property p_off; s0 && $rose(os_req.soft_off) |-> ##[1:4] s5; endproperty
  a_off: assert property (p_off) else $error("no soft off");
  property p_saved; (s0 || s5) && $stable(sys_state) |-> state_saved_on == s0; endproperty
  a_saved: assert property (p_saved) else $error("saved state");
  // sleep event pulse only beside a switch suspend out of S0
  property p_sleep_btn; power_out.sleep_button |-> s3 && $past(s0); endproperty
  a_sleep_btn: assert property (p_sleep_btn) else $error("stray sleep event");
  // main paths seen
  c_cold: cover property (s0 && $past(s5));
  c_resume: cover property (s0 && $past(s3));
  c_s1: cover property (s1 && $past(s0));
  c_btn: cover property (power_out.sleep_button);
endmodule
bind pbwc_top pbwc_asserts u_asserts (.ref_clk(ref_clk), .reset_n(reset_n),
  .pwr_switch_n(pwr_switch_n), .wake_in(wake_in), .os_req(os_req), .power_out(power_out),
  .sys_state(sys_state), .state_saved_on(state_saved_on));
`default_nettype wire

// file: pbwc_far.sv
/* pbwc_far: front switch and wake-capable devices.
   assumes: the bench calls its tasks one at a time. */
`timescale 1ns/1ps
`default_nettype none
module pbwc_far (
  // clock
  input  wire logic           ref_clk,
  // pins
  output var  logic           pwr_switch_n,
  output var  pbwc_pkg::pbwc_wake_t wake_in
);
  // idle: switch pulled up, wake lines low
  initial begin
    pwr_switch_n = 1'b1;
    wake_in = '0;
  end
  // hold the switch n cycles; edges just after the clock
  task automatic press(input int n);
    @(posedge ref_clk) pwr_switch_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    pwr_switch_n <= 1'b1;
  endtask
  // short level: dropped so a later sleep is not woken at once
  task automatic wake(input int b);
    @(posedge ref_clk) wake_in[b] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wake_in <= '0;
  endtask
endmodule
`default_nettype wire

// file: test_pbwc_top.sv
/* test_pbwc_top: scenario bench for the power controller.
   assumes: pbwc_far at the pins, checker bound to dut. */
`timescale 1ns/1ps
`default_nettype none
module test_pbwc_top;
  logic                   ref_clk;
  logic                   reset_n;
  logic                   pwr_switch_n;
  pbwc_pkg::pbwc_wake_t   wake_in;
  pbwc_pkg::pbwc_os_req_t os_req;
  logic                   soft_off_en;
  logic                   last_on_state;
  pbwc_pkg::pbwc_power_t  power_out;
  pbwc_pkg::pbwc_state_t  sys_state;
  logic                   state_saved_on;
  int                     errors;
  int                     n_tests;
  int                     cyc;
  // short counts keep the run brief
  pbwc_top #(.DEBOUNCE_CYCLES(4), .LONG_CYCLES(40)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .pwr_switch_n(pwr_switch_n), .wake_in(wake_in), .os_req(os_req), .soft_off_en(soft_off_en),
    .last_on_state(last_on_state), .power_out(power_out), .sys_state(sys_state),
    .state_saved_on(state_saved_on));
  pbwc_far u_far (.ref_clk(ref_clk), .pwr_switch_n(pwr_switch_n), .wake_in(wake_in));
  // ====================
  // 250 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for a state, then its rails
  task automatic ws(input logic [4:0] st);
    logic [4:0] pw;
    pw = (st == 5'h01) ? 5'h1c : (st == 5'h02) ? 5'h1f : (st == 5'h04) ? 5'h07 : 5'h03;
    @(negedge ref_clk);
    for (int i = 0; i < 300 && sys_state !== st; i++) @(negedge ref_clk);
    chk(sys_state, st);
    chk({power_out.supply_on, power_out.cpu_power, power_out.mem_power, power_out.dev_state}, pw);
  endtask
  // os request held past the synchroniser
  task automatic os(input logic [2:0] r);
    @(posedge ref_clk) os_req <= r;
    repeat (4) @(posedge ref_clk);
    os_req <= '0;
  endtask
  task automatic rst(input logic en, input logic last);
    @(posedge ref_clk) reset_n <= 1'b0;
    soft_off_en <= en;
    last_on_state <= last;
    repeat (3) @(posedge ref_clk);
    chk(sys_state, 5'h10);
    reset_n <= 1'b1;
  endtask
  // ====================
  // switch presses from off and working, usb wake from sleep
  task automatic t_switch;
    ws(5'h08);
    for (int b = 0; b < 3; b++) u_far.wake(b);
    repeat (12) @(negedge ref_clk);
    chk(sys_state, 5'h08);
    u_far.press(10);
    ws(5'h01);
    u_far.press(10);
    ws(5'h04);
    u_far.wake(0);
    ws(5'h01);
    u_far.press(60);
    repeat (12) @(negedge ref_clk);
    ws(5'h08);
  endtask
  // os driven sleep, wakes, long press from sleep
  task automatic t_sleep;
    u_far.wake(3);
    ws(5'h01);
    os(3'h4);
    ws(5'h02);
    u_far.wake(1);
    ws(5'h01);
    os(3'h2);
    ws(5'h04);
    u_far.wake(2);
    ws(5'h01);
    os(3'h4);
    u_far.press(25);
    ws(5'h01);
    os(3'h2);
    u_far.press(60);
    ws(5'h08);
    os(3'h1);
    u_far.wake(3);
    ws(5'h01);
    @(negedge ref_clk);
    chk({4'h0, state_saved_on}, 5'h01);
    os(3'h1);
    ws(5'h08);
  endtask
  // mains restore policy across resets
  task automatic t_restore;
    rst(1'b1, 1'b1);
    ws(5'h01);
    // stored level fed back as battery storage would keep it
    rst(1'b1, state_saved_on);
    ws(5'h01);
    os(3'h1);
    ws(5'h08);
    rst(1'b1, state_saved_on);
    ws(5'h08);
    rst(1'b1, 1'b0);
    ws(5'h08);
    rst(1'b0, 1'b1);
    ws(5'h08);
  endtask
  task automatic end_of_test;
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // cycle ceiling: a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    errors = 0;
    n_tests = 0;
    cyc = 0;
    reset_n = 1'b0;
    os_req = '0;
    soft_off_en = 1'b0;
    last_on_state = 1'b0;
    rst(1'b0, 1'b0);
    t_switch();
    t_sleep();
    t_restore();
    end_of_test();
  end
endmodule
`default_nettype wire
